// ==== pwm_timer.sv ====
// Compare-driven PWM output stage with prescaled 16-bit counter
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module pwm_timer
	import pwm_timer_pkg::*;
(
	input  wire logic              MCLK,           // 50 MHz clock
	input  wire logic              RST,            // Synchronous reset
	input  wire logic              CE,             // Freezes all state
	input  wire logic [ADDR_W-1:0] AV_ADDRESS,     // Byte address
	input  wire logic              AV_READ,        // Read request
	input  wire logic              AV_WRITE,       // Write request
	input  wire logic [DATA_W-1:0] AV_WRITEDATA,   // Write data
	input  wire logic [3:0]        AV_BYTEENABLE,  // Byte lanes
	output logic      [DATA_W-1:0] AV_READDATA,    // Read data
	output logic                   AV_WAITREQUEST, // Stall
	input  wire logic              PWM_PIN_B_IN,   // Pin level seen
	output logic                   PWM_PIN_B_OUT,  // Pin level driven
	output logic                   PWM_PIN_B_OE    // Pin drive enable
);

	// ************************************************************
	// State and helpers
	// ************************************************************
	state_t          q;          // Registered state
	state_t          d;          // Next state
	logic            pwm_on;     // Output function active
	logic            fall;       // Falling edge on the pin
	logic            tick;       // One timer input clock
	logic [9:0]      pre_lim;    // Prescaler terminal count
	logic            acc;        // Bus access completes now
	logic            wr_hit;     // Bus write completes now
	logic            up_pwm;     // Up/down PWM in force
	logic            cmp_hit;    // Count equals compare
	logic            top_hit;    // Count equals reload
	logic            zero_hit;   // Count is zero
	logic [31:0]     rd_mux;     // Read data selection
	logic [31:0]     ctrl_img;   // Control register image

	// Merge written bytes into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	// ************************************************************
	// Decode of present state
	// ************************************************************
	always_comb begin
		pwm_on   = (q.fsel != FN_OFF);
		fall     = q.pin_s3 & ~q.pin_s2;
		up_pwm   = q.updown & pwm_on;
		cmp_hit  = (q.count == q.compare);
		top_hit  = (q.count == q.reload);
		zero_hit = (q.count == 16'h0000);
		acc      = ~q.wait_r & (AV_READ | AV_WRITE);
		wr_hit   = ~q.wait_r & AV_WRITE;
		// Divisor from the prescale select
		unique case (q.ps)
			3'h1:    pre_lim = PRE_DIV4;
			3'h2:    pre_lim = PRE_DIV16;
			3'h3:    pre_lim = PRE_DIV64;
			3'h4:    pre_lim = PRE_DIV256;
			3'h5:    pre_lim = PRE_DIV1024;
			default: pre_lim = PRE_DIV1;
		endcase
		tick     = q.run & (q.pre == pre_lim);
		// Register images
		ctrl_img = 32'h0000_0000;
		ctrl_img[CTRL_RUN]                = q.run;
		ctrl_img[CTRL_SET_B:CTRL_RST_B]   = q.fsel;
		ctrl_img[CTRL_PS_LO+2:CTRL_PS_LO] = q.ps;
		ctrl_img[CTRL_UPDOWN]             = q.updown;
		ctrl_img[CTRL_EV_EN]              = q.ev_en;
		rd_mux   = 32'h0000_0000;
		// Unmapped addresses read zero
		unique case (AV_ADDRESS)
			OFS_CTRL: begin
				rd_mux = ctrl_img;
			end
			OFS_STATUS: begin
				rd_mux[STAT_FLAG]  = q.flag;
				rd_mux[STAT_LEVEL] = q.out;
				rd_mux[STAT_DIRUP] = q.dir_up;
			end
			OFS_COUNT: begin
				rd_mux[15:0] = q.count;
			end
			OFS_RELOAD: begin
				rd_mux[15:0] = q.reload;
			end
			OFS_COMPARE: begin
				rd_mux[15:0] = q.compare;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		logic [31:0] w;
		w = 32'h0000_0000;
		d = q;
		// Two-stage pin synchroniser, then edge history
		d.pin_s1 = PWM_PIN_B_IN;
		d.pin_s2 = q.pin_s1;
		d.pin_s3 = q.pin_s2;

		// Prescaler runs only with the timer
		if (!q.run || tick) begin
			d.pre = 10'h000;
		end else begin
			d.pre = q.pre + 10'h001;
		end

		// Counter step on each input clock
		if (tick) begin
			if (up_pwm) begin
				// Direction decided internally, pin ignored
				if (q.reload == 16'h0000) begin
					d.count = 16'h0000;
				end else if (q.dir_up && top_hit) begin
					d.count  = q.reload - 16'h0001;
					d.dir_up = 1'b0;
				end else if (!q.dir_up && zero_hit) begin
					d.count  = 16'h0001;
					d.dir_up = 1'b1;
				end else if (q.dir_up) begin
					d.count = q.count + 16'h0001;
				end else begin
					d.count = q.count - 16'h0001;
				end
			end else if (q.updown) begin
				// Plain up/down: pin level sets direction
				d.dir_up = q.pin_s2;
				if (q.pin_s2) begin
					d.count = top_hit ? 16'h0000
						: q.count + 16'h0001;
				end else begin
					d.count = zero_hit ? q.reload
						: q.count - 16'h0001;
				end
			end else begin
				// Edge-aligned: 0 .. reload, then restart
				d.dir_up = 1'b1;
				d.count  = top_hit ? 16'h0000
					: q.count + 16'h0001;
			end
		end

		// External reload only without PWM, up-count mode
		if (q.ev_en && fall && !pwm_on && !q.updown) begin
			d.count = 16'h0000;
		end

		// Output level: starting state while stopped
		if (!q.run) begin
			unique case (q.fsel)
				FN_RESET: d.out = 1'b0;
				FN_SET:   d.out = 1'b1;
				default:  d.out = q.out;
			endcase
		end else if (tick) begin
			// Compare actions; mode change alone does nothing
			unique case (q.fsel)
				FN_RESET: begin
					if (cmp_hit && !zero_hit) begin
						d.out = 1'b0;
					end else if (zero_hit) begin
						d.out = 1'b1;
					end
				end
				FN_SET: begin
					if (top_hit) begin
						d.out = 1'b0;
					end else if (cmp_hit) begin
						d.out = 1'b1;
					end
				end
				FN_TOGGLE: begin
					if (cmp_hit && !zero_hit && !top_hit) begin
						d.out = ~q.out;
					end
				end
				default: begin
					d.out = q.out;
				end
			endcase
		end

		// Pin event flag: a set beats a clear
		if (wr_hit && AV_ADDRESS == OFS_STATUS && AV_BYTEENABLE[0]
			&& AV_WRITEDATA[STAT_FLAG]) begin
			d.flag = 1'b0;
		end
		if (q.ev_en && fall) begin
			d.flag = 1'b1;
		end

		// Avalon slave: answer one cycle after the request
		if (q.wait_r && (AV_READ | AV_WRITE)) begin
			d.wait_r = 1'b0;
			d.rdata  = AV_READ ? rd_mux : 32'h0000_0000;
		end else if (acc) begin
			d.wait_r = 1'b1;
		end

		// Register writes land at the completing edge
		if (wr_hit) begin
			unique case (AV_ADDRESS)
				OFS_CTRL: begin
					w = merge(ctrl_img, AV_WRITEDATA, AV_BYTEENABLE);
					d.run    = w[CTRL_RUN];
					d.fsel   = fsel_t'(w[CTRL_SET_B:CTRL_RST_B]);
					d.ps     = w[CTRL_PS_LO+2:CTRL_PS_LO];
					d.updown = w[CTRL_UPDOWN];
					d.ev_en  = w[CTRL_EV_EN];
				end
				OFS_COUNT: begin
					w = merge({16'h0000, q.count}, AV_WRITEDATA,
						AV_BYTEENABLE);
					d.count = w[15:0];
				end
				OFS_RELOAD: begin
					w = merge({16'h0000, q.reload}, AV_WRITEDATA,
						AV_BYTEENABLE);
					d.reload = w[15:0];
				end
				OFS_COMPARE: begin
					w = merge({16'h0000, q.compare}, AV_WRITEDATA,
						AV_BYTEENABLE);
					d.compare = w[15:0];
				end
				default: begin
					w = 32'h0000_0000;
				end
			endcase
		end

		// Drive follows run and function as written, so the start
		// level is on the pin before the first tick can change it
		d.oe = d.run & (d.fsel != FN_OFF);
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge MCLK) begin
		if (RST) begin
			q <= '{wait_r: 1'b1, rdata: 32'h0000_0000, run: 1'b0,
				fsel: FN_OFF, ps: RST_PS, updown: 1'b0,
				ev_en: 1'b0, flag: 1'b0, count: RST_COUNT,
				reload: RST_RELOAD, compare: RST_COMPARE,
				pre: 10'h000, dir_up: 1'b1, out: 1'b0, oe: 1'b0,
				pin_s1: 1'b0, pin_s2: 1'b0, pin_s3: 1'b0};
		end else if (CE) begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign AV_READDATA    = q.rdata;
	assign AV_WAITREQUEST = q.wait_r;
	assign PWM_PIN_B_OUT  = q.out;
	assign PWM_PIN_B_OE   = q.oe;

	// ************************************************************
	// Assertions
	// ************************************************************
	flag_on_fall_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && q.ev_en && fall |=> q.flag)
		else $error("pin event flag missed a falling edge");

	no_pwm_reload_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && pwm_on && !q.updown && q.ev_en && fall && !tick
		&& !wr_hit |=> $stable(q.count))
		else $error("pin edge reloaded counter during PWM");

	stop_low_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && !q.run && q.fsel == FN_RESET |=> !q.out)
		else $error("reset mode start level not low");

	stop_high_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && !q.run && q.fsel == FN_SET |=> q.out)
		else $error("set mode start level not high");

	drive_start_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && $rose(q.run) && pwm_on |-> q.oe && q.out == $past(q.out))
		else $error("start level not driven at run start");

	toggle_idle_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && q.run && tick && q.fsel == FN_TOGGLE
		&& (q.compare == 16'h0000 || q.compare == q.reload)
		|=> $stable(q.out))
		else $error("toggle fired at a bound value");

	reset_zero_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && q.run && tick && q.fsel == FN_RESET
		&& q.compare == 16'h0000 |=> !$fell(q.out))
		else $error("reset mode cleared with compare zero");

	set_top_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && q.run && tick && q.fsel == FN_SET
		&& q.compare == q.reload |=> !$rose(q.out))
		else $error("set mode set with compare at reload");

	peak_turn_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && tick && up_pwm && q.dir_up && top_hit
		&& q.reload != 16'h0000 && !wr_hit
		|=> !q.dir_up && q.count == $past(q.reload) - 16'h0001)
		else $error("up/down count did not turn at reload");

	edge_wrap_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && tick && !q.updown && top_hit && !wr_hit
		|=> q.count == 16'h0000)
		else $error("up count did not restart after reload");

	bottom_turn_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && tick && up_pwm && !q.dir_up && zero_hit
		&& q.reload != 16'h0000 && !wr_hit
		|=> q.dir_up && q.count == 16'h0001)
		else $error("up/down count did not turn at zero");

	own_direction_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && tick && up_pwm && !top_hit && !zero_hit
		|=> q.dir_up == $past(q.dir_up))
		else $error("up/down direction changed inside range");

	toggle_flip_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && q.run && tick && q.fsel == FN_TOGGLE && cmp_hit
		&& !zero_hit && !top_hit |=> q.out != $past(q.out))
		else $error("toggle missed a compare match");

	zero_set_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && q.run && tick && q.fsel == FN_RESET && zero_hit
		|=> q.out)
		else $error("reset mode not set at count zero");

	reload_clear_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && q.run && tick && q.fsel == FN_SET && top_hit
		|=> !q.out)
		else $error("set mode not cleared at reload");

	off_release_a: assert property (@(posedge MCLK) disable iff (RST)
		CE && q.fsel == FN_OFF && !wr_hit |=> !q.oe)
		else $error("pin driven with output function off");

endmodule
`default_nettype wire

// ==== pwm_timer_pkg.sv ====
// Shared constants, types and state layout of the compare PWM timer block
`default_nettype none
package pwm_timer_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int          CNT_W   = 16;      // Count, reload, compare
	localparam int          DATA_W  = 32;      // Avalon data width
	localparam int          ADDR_W  = 5;       // Avalon byte address width
	localparam int          PRE_W   = 10;      // Prescaler counter width

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [4:0]  OFS_CTRL    = 5'h00; // timer_control
	localparam logic [4:0]  OFS_STATUS  = 5'h04; // Flag and live state
	localparam logic [4:0]  OFS_COUNT   = 5'h08; // count_value
	localparam logic [4:0]  OFS_RELOAD  = 5'h0c; // reload_value
	localparam logic [4:0]  OFS_COMPARE = 5'h10; // compare_value

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int          CTRL_RUN    = 0;   // run_control
	localparam int          CTRL_RST_B  = 1;   // output_reset_mode_bit
	localparam int          CTRL_SET_B  = 2;   // output_set_mode_bit
	localparam int          CTRL_PS_LO  = 3;   // clock_prescale_select
	localparam int          CTRL_UPDOWN = 6;   // updown_count_enable
	localparam int          CTRL_EV_EN  = 7;   // pin_event_enable
	localparam int          STAT_FLAG   = 0;   // pin_event_flag, W1C
	localparam int          STAT_LEVEL  = 1;   // Present output level
	localparam int          STAT_DIRUP  = 2;   // Counting upward

	// ************************************************************
	// Values after reset
	// ************************************************************
	localparam logic [15:0] RST_COUNT   = 16'h0000;
	localparam logic [15:0] RST_RELOAD  = 16'h0000;
	localparam logic [15:0] RST_COMPARE = 16'h0000;
	localparam logic [2:0]  RST_PS      = 3'h0;

	// ************************************************************
	// Prescaler terminal counts (divisor minus one)
	// ************************************************************
	localparam logic [9:0]  PRE_DIV1    = 10'h000;
	localparam logic [9:0]  PRE_DIV4    = 10'h003;
	localparam logic [9:0]  PRE_DIV16   = 10'h00f;
	localparam logic [9:0]  PRE_DIV64   = 10'h03f;
	localparam logic [9:0]  PRE_DIV256  = 10'h0ff;
	localparam logic [9:0]  PRE_DIV1024 = 10'h3ff;

	// Output function select codes
	typedef enum logic [1:0] {
		FN_OFF    = 2'b00,
		FN_RESET  = 2'b01,
		FN_SET    = 2'b10,
		FN_TOGGLE = 2'b11
	} fsel_t;

	// Whole state of the block
	typedef struct packed {
		logic              wait_r;  // Avalon waitrequest
		logic [31:0]       rdata;   // Avalon read data
		logic              run;     // run_control
		fsel_t             fsel;    // output_function_select
		logic [2:0]        ps;      // clock_prescale_select
		logic              updown;  // updown_count_enable
		logic              ev_en;   // pin_event_enable
		logic              flag;    // pin_event_flag
		logic [15:0]       count;   // count_value
		logic [15:0]       reload;  // reload_value
		logic [15:0]       compare; // compare_value
		logic [9:0]        pre;     // Prescaler counter
		logic              dir_up;  // Count direction
		logic              out;     // PWM level
		logic              oe;      // Pin drive enable
		logic              pin_s1;  // Synchroniser stage one
		logic              pin_s2;  // Synchroniser stage two
		logic              pin_s3;  // Previous synced level
	} state_t;

endpackage
`default_nettype wire

// ==== pwm_pin_model.sv ====
// Outside circuit on the PWM pin: pull-up plus a switch to ground
`timescale 1ns/1ns
`default_nettype none
module pwm_pin_model (
	input  wire logic oe,      // Block drives the pin
	input  wire logic drv,     // Level the block drives
	input  wire logic pull_lo, // Outside switch pulls pin low
	output logic      level    // Resolved wire level
);
	// ************************************************************
	// Wire resolution
	// ************************************************************
	// A released pin rests at the pull-up level unless pulled low
	always_comb begin
		if (oe)
			level = drv;
		else
			level = !pull_lo;
	end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the compare PWM timer block
`timescale 1ns/1ns
`default_nettype none
module tb
	import pwm_timer_pkg::*;
;
	logic              mclk = 1'b0;    // System clock
	logic              rst = 1'b1;     // Synchronous reset
	logic [ADDR_W-1:0] av_address = '0; // Bus address
	logic              av_read = 1'b0;  // Bus read
	logic              av_write = 1'b0; // Bus write
	logic [DATA_W-1:0] av_wdata = '0;   // Bus write data
	logic [DATA_W-1:0] av_rdata;        // Bus read data
	logic              av_wait;         // Bus stall
	logic              pwm_out;         // Driven level
	logic              pwm_oe;          // Drive enable
	logic              pin_lvl;         // Resolved pin
	logic              pull_lo = 1'b0;  // Outside pull-down
	logic [31:0]       rd;              // Last read word
	int                bad_count = 0;   // Mismatches
	int                num_checks = 0;  // Comparisons

	// 50 MHz clock
	always #10 mclk = ~mclk;

	pwm_timer u_dut (
		.MCLK(mclk), .RST(rst), .CE(1'b1), .AV_ADDRESS(av_address),
		.AV_READ(av_read), .AV_WRITE(av_write), .AV_WRITEDATA(av_wdata),
		.AV_BYTEENABLE(4'hf), .AV_READDATA(av_rdata),
		.AV_WAITREQUEST(av_wait), .PWM_PIN_B_IN(pin_lvl),
		.PWM_PIN_B_OUT(pwm_out), .PWM_PIN_B_OE(pwm_oe)
	);

	pwm_pin_model u_pin (
		.oe(pwm_oe), .drv(pwm_out), .pull_lo(pull_lo), .level(pin_lvl)
	);

	// ************************************************************
	// Shared tasks
	// ************************************************************
	// Verdict and end of run
	task automatic complete_run();
		if (bad_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Compare one value
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One bus access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		av_address <= a;
		av_write <= wr;
		av_read <= !wr;
		av_wdata <= d;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (av_wait !== 1'b0 && n < 40);
		if (n >= 40) begin
			bad_count++;
			$display("ERROR %0t bus timeout", $time);
			complete_run();
		end
		@(posedge mclk);
		rd = av_rdata;
		av_read <= 1'b0;
		av_write <= 1'b0;
	endtask

	// Program while stopped, check start level, then start
	task automatic setup(input fsel_t pre, input fsel_t fs,
			input logic [2:0] ps, input logic ud,
			input logic [15:0] rl, input logic [15:0] cp);
		bus(1'b1, OFS_CTRL, {24'h0, 1'b1, ud, ps, pre, 1'b0});
		bus(1'b1, OFS_COUNT, 32'h0);
		bus(1'b1, OFS_RELOAD, {16'h0, rl});
		bus(1'b1, OFS_COMPARE, {16'h0, cp});
		bus(1'b0, OFS_STATUS, 32'h0);
		if (pre != FN_OFF)
			check(32'(rd[STAT_LEVEL]), 32'(pre == FN_SET));
		check(32'(pwm_oe), 32'h0);
		bus(1'b1, OFS_CTRL, {24'h0, 1'b1, ud, ps, fs, 1'b1});
	endtask

	// Count high cycles on the pin over a window; check drive and flag
	task automatic measure(input int skip, input int n, input int hi);
		int h;
		int off;
		h = 0;
		off = 0;
		repeat (skip) @(posedge mclk);
		bus(1'b1, OFS_STATUS, 32'h1);
		repeat (n) begin
			@(posedge mclk);
			#1;
			h += int'(pin_lvl === 1'b1);
			off += int'(pwm_oe !== 1'b1);
		end
		check(32'(h), 32'(hi));
		check(32'(off), 32'h0);
		bus(1'b0, OFS_STATUS, 32'h0);
		check(32'(rd[STAT_FLAG]), 32'(hi > 0 && hi < n));
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	// Edge-aligned set, reset and toggle, reload 7, compare 3
	task automatic t_upcount();
		setup(FN_RESET, FN_RESET, 3'h0, 1'b0, 16'h7, 16'h3);
		measure(8, 64, 24);
		setup(FN_SET, FN_SET, 3'h0, 1'b0, 16'h7, 16'h3);
		measure(8, 64, 32);
		setup(FN_OFF, FN_TOGGLE, 3'h0, 1'b0, 16'h7, 16'h3);
		measure(16, 64, 32);
	endtask

	// Compare at the bounds of the count range
	task automatic t_bounds();
		setup(FN_RESET, FN_RESET, 3'h0, 1'b0, 16'h7, 16'h0);
		measure(16, 64, 64);
		setup(FN_SET, FN_SET, 3'h0, 1'b0, 16'h7, 16'h7);
		measure(16, 64, 0);
		setup(FN_SET, FN_TOGGLE, 3'h0, 1'b0, 16'h7, 16'h0);
		measure(16, 64, 64);
		setup(FN_RESET, FN_TOGGLE, 3'h0, 1'b0, 16'h7, 16'h7);
		measure(16, 64, 0);
	endtask

	// Center-aligned modes, reload 8, compare 2
	task automatic t_updown();
		setup(FN_RESET, FN_RESET, 3'h0, 1'b1, 16'h8, 16'h2);
		measure(16, 64, 8);
		setup(FN_SET, FN_SET, 3'h0, 1'b1, 16'h8, 16'h2);
		measure(16, 64, 40);
		setup(FN_SET, FN_TOGGLE, 3'h0, 1'b1, 16'h8, 16'h2);
		measure(16, 64, 16);
	endtask

	// Prescale codes 0 to 4, reload 3, compare 1
	task automatic t_prescale();
		int div;
		for (int i = 0; i < 5; i++) begin
			div = 1 << (2 * i);
			setup(FN_RESET, FN_RESET, 3'(i), 1'b0, 16'h3, 16'h1);
			measure(4 * div, 16 * div, 4 * div);
		end
	endtask

	// Start level on the pin, then a mode change while running
	task automatic t_hold();
		setup(FN_SET, FN_SET, 3'h4, 1'b0, 16'h3, 16'h1);
		@(posedge mclk);
		#1;
		check(32'({pwm_oe, pwm_out}), 32'h3);
		bus(1'b1, OFS_CTRL, {24'h0, 1'b1, 1'b0, 3'h4, FN_RESET, 1'b1});
		#1;
		check(32'(pwm_out), 32'h1);
	endtask

	// Code 00 drives nothing; outside falls while stopped
	task automatic t_event();
		setup(FN_OFF, FN_OFF, 3'h0, 1'b0, 16'h7, 16'h3);
		repeat (20) @(posedge mclk);
		check(32'(pwm_oe), 32'h0);
		for (int e = 1; e >= 0; e--) begin
			bus(1'b1, OFS_CTRL, {24'h0, 1'(e), 7'h0});
			bus(1'b1, OFS_STATUS, 32'h1);
			pull_lo <= 1'b1;
			repeat (8) @(posedge mclk);
			bus(1'b0, OFS_STATUS, 32'h0);
			check(32'(rd[STAT_FLAG]), 32'(e));
			pull_lo <= 1'b0;
			repeat (4) @(posedge mclk);
		end
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		bus(1'b0, OFS_CTRL, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, 5'h14, 32'hffff);
		bus(1'b0, 5'h14, 32'h0);
		check(rd, 32'h0);
		t_upcount();
		t_bounds();
		t_updown();
		t_prescale();
		t_hold();
		t_event();
		complete_run();
	end
endmodule
`default_nettype wire
